/* rtl/tes_params.svh */
`ifndef TES_PARAMS_SVH
`define TES_PARAMS_SVH

// Register offsets.
`define TES_ADDR_EXCEED 8'h2d
`define TES_ADDR_INSIDE 8'h2e
`define TES_ADDR_CFG1 8'h2f
`define TES_ADDR_CFG2 8'h30
`define TES_ADDR_UTH_LO 8'h31
`define TES_ADDR_UTH_HI 8'h32
`define TES_ADDR_LTH_LO 8'h33
`define TES_ADDR_LTH_HI 8'h34
`define TES_ADDR_ODB 8'h35
`define TES_ADDR_IDB 8'h36
`define TES_ADDR_CFG4 8'h37
`define TES_ADDR_IRQ_ST 8'h38
`define TES_ADDR_IRQ_MSK 8'h39

// Exceed status fields.
`define TES_EX_ACTIVE 7
`define TES_EX_X_FLAG 5
`define TES_EX_X_POL 4
`define TES_EX_Y_FLAG 3
`define TES_EX_Y_POL 2
`define TES_EX_Z_FLAG 1
`define TES_EX_Z_POL 0

// Inside status fields.
`define TES_IN_ACTIVE 7
`define TES_IN_X_FLAG 5
`define TES_IN_Y_FLAG 3
`define TES_IN_Z_FLAG 1

// Detector config one fields.
`define TES_C1_OUT_LATCH 7
`define TES_C1_IN_LATCH 6
`define TES_C1_OUT_EN_LSB 3
`define TES_C1_IN_EN_LSB 0

// Detector config two and sensor config four fields.
`define TES_C2_LOGIC_ANY 0
`define TES_C4_WAKE_HOLD 0
`define TES_C4_IN_PIN_TWO 1
`define TES_C4_OUT_PIN_TWO 2

// Interrupt status fields.
`define TES_IRQ_INSIDE 0
`define TES_IRQ_OUTSIDE 1

// Reset values.
`define TES_RST_CFG 8'h00
`define TES_RST_UTH 16'h0000
`define TES_RST_LTH 16'h0000
`define TES_RST_DB 8'h00

`endif

/* rtl/tes_pkg.sv */
package tes_pkg;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } tes_bus_type;

   // Index 2 is X, 1 is Y, 0 is Z.
   typedef logic [2:0][15:0] tes_axes_type;

   typedef struct packed {
      logic [7:0] cfg1;
      logic [7:0] cfg2;
      logic [15:0] uth;
      logic [15:0] lth;
      logic [7:0] odb;
      logic [7:0] idb;
      logic [7:0] cfg4;
      logic [1:0] irq_st;
      logic [1:0] irq_msk;
      logic [2:0] ot_flag;
      logic [2:0] ot_pol;
      logic oa;
      logic [7:0] o_cnt;
      logic o_arm;
      logic [2:0] in_flag;
      logic ia;
      logic [7:0] i_cnt;
      logic i_arm;
      logic [7:0] rdata;
      logic irq;
      logic pin1;
      logic pin2;
      logic wake;
   } tes_state_type;

endpackage

/* rtl/tes_top.sv */
`timescale 1ns/1ps
`include "tes_params.svh"
// Summary of operation
// - Y outside flag set at or beyond a threshold, cleared between unless latched, when enabled.
// - Z outside flag at bit 1 uses the same comparison when enabled.
// - Polarity bits Y at 2, Z at 0: one above upper, zero below lower.
// - Polarity is captured whenever its outside flag becomes set.
// - Without latching, polarity updates while flagged and outside debounce reached.
// - Inside active sets when all or any enabled axes stay inside long enough.
// - No inside enable bits set means inside detection is off.
// - Wake hold restarts the sleep timer each sample while inside active.
// - X inside flag at bit 5 shows X strictly between thresholds.
// - Y inside flag at bit 3 shows Y strictly between thresholds.
// - Latched inside flags capture on active rise, held until status read.
// - Unlatched inside flags update when active and inside debounce reached.
// - Unlatched with zero inside debounce, flags update even when inactive.
// - Inside active can be routed to either interrupt pin.
// - Outside active sets when any outside flag lasts the outside debounce.
// - Latched mode asserts active only on a false to true condition edge.
module tes_top #(
   parameter int DATA_BITS = 12
) (
   // Clock and reset.
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   // Sample stream from the sensor datapath, same clock domain.
   input wire logic odr_tick_in,
   input wire tes_pkg::tes_axes_type axes_in,
   // Register port.
   input wire tes_pkg::tes_bus_type bus_in,
   output logic [7:0] read_data_out,
   // Interrupts and power control.
   output logic irq_out,
   output logic interrupt_pin_one_out,
   output logic interrupt_pin_two_out,
   output logic sleep_timer_restart_out
);
   import tes_pkg::*;

   if (DATA_BITS < 2 || DATA_BITS > 16) begin : g_check
      $error("DATA_BITS must lie between 2 and 16");
   end

   localparam int SHIFT = 16 - DATA_BITS;

   tes_state_type state_reg;
   tes_state_type state_next;

   ////////////////////////////////////////////////////////////////////////////////

   // Data and thresholds both use the low DATA_BITS bits, sign extended.
   function automatic logic signed [15:0] sext(input logic [15:0] v);
      logic signed [15:0] t;
      t = $signed(v << SHIFT);
      return t >>> SHIFT;
   endfunction

   function automatic logic inside_win(input logic [15:0] v, input logic [15:0] up,
                                       input logic [15:0] lo);
      return (sext(v) < sext(up)) && (sext(v) > sext(lo));
   endfunction

   // Saturating so a long event never wraps back below the debounce count.
   function automatic logic [7:0] deb_step(input logic cond, input logic [7:0] cnt);
      if (!cond) begin
         return 8'h00;
      end
      if (cnt == 8'hff) begin
         return cnt;
      end
      return cnt + 8'h01;
   endfunction

   function automatic logic [7:0] read_mux(input tes_state_type s, input logic [7:0] a);
      logic [7:0] r;
      r = 8'h00;
      case (a)
         `TES_ADDR_EXCEED: begin
            r[`TES_EX_ACTIVE] = s.oa;
            r[`TES_EX_X_FLAG] = s.ot_flag[2];
            r[`TES_EX_X_POL] = s.ot_pol[2];
            r[`TES_EX_Y_FLAG] = s.ot_flag[1];
            r[`TES_EX_Y_POL] = s.ot_pol[1];
            r[`TES_EX_Z_FLAG] = s.ot_flag[0];
            r[`TES_EX_Z_POL] = s.ot_pol[0];
         end
         `TES_ADDR_INSIDE: begin
            r[`TES_IN_ACTIVE] = s.ia;
            r[`TES_IN_X_FLAG] = s.in_flag[2];
            r[`TES_IN_Y_FLAG] = s.in_flag[1];
            r[`TES_IN_Z_FLAG] = s.in_flag[0];
         end
         `TES_ADDR_CFG1: r = s.cfg1;
         `TES_ADDR_CFG2: r = s.cfg2;
         `TES_ADDR_UTH_LO: r = s.uth[7:0];
         `TES_ADDR_UTH_HI: r = s.uth[15:8];
         `TES_ADDR_LTH_LO: r = s.lth[7:0];
         `TES_ADDR_LTH_HI: r = s.lth[15:8];
         `TES_ADDR_ODB: r = s.odb;
         `TES_ADDR_IDB: r = s.idb;
         `TES_ADDR_CFG4: r = s.cfg4;
         `TES_ADDR_IRQ_ST: r = {6'h00, s.irq_st};
         `TES_ADDR_IRQ_MSK: r = {6'h00, s.irq_msk};
         default: r = 8'h00;
      endcase
      return r;
   endfunction

   // Both pins share one routing rule; a route bit of one selects the second pin.
   function automatic logic pin_level(input logic ia, input logic oa, input logic [7:0] cfg4,
                                      input logic second);
      logic in_sel;
      logic out_sel;
      in_sel = cfg4[`TES_C4_IN_PIN_TWO] == second;
      out_sel = cfg4[`TES_C4_OUT_PIN_TWO] == second;
      return (ia && in_sel) || (oa && out_sel);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////

   always_comb begin
      logic [2:0] inw;
      logic [2:0] above;
      logic [2:0] out_en;
      logic [2:0] in_en;
      logic [2:0] outw;
      logic [2:0] rise;
      logic o_cond;
      logic o_reach;
      logic i_cond;
      logic i_reach;
      logic [7:0] oc;
      logic [7:0] ic;
      logic [1:0] ev;
      logic ole;
      logic ile;
      inw = 3'h0;
      above = 3'h0;
      rise = 3'h0;
      ev = 2'h0;
      outw = 3'h0;
      o_cond = 1'b0;
      o_reach = 1'b0;
      i_cond = 1'b0;
      i_reach = 1'b0;
      oc = 8'h00;
      ic = 8'h00;
      state_next = state_reg;
      state_next.rdata = 8'h00;
      state_next.wake = 1'b0;
      ole = state_reg.cfg1[`TES_C1_OUT_LATCH];
      ile = state_reg.cfg1[`TES_C1_IN_LATCH];
      out_en = state_reg.cfg1[`TES_C1_OUT_EN_LSB +: 3];
      in_en = state_reg.cfg1[`TES_C1_IN_EN_LSB +: 3];

      // Register writes.
      if (bus_in.wr) begin
         case (bus_in.addr)
            `TES_ADDR_CFG1: state_next.cfg1 = bus_in.wdata;
            `TES_ADDR_CFG2: state_next.cfg2 = bus_in.wdata;
            `TES_ADDR_UTH_LO: state_next.uth[7:0] = bus_in.wdata;
            `TES_ADDR_UTH_HI: state_next.uth[15:8] = bus_in.wdata;
            `TES_ADDR_LTH_LO: state_next.lth[7:0] = bus_in.wdata;
            `TES_ADDR_LTH_HI: state_next.lth[15:8] = bus_in.wdata;
            `TES_ADDR_ODB: state_next.odb = bus_in.wdata;
            `TES_ADDR_IDB: state_next.idb = bus_in.wdata;
            `TES_ADDR_CFG4: state_next.cfg4 = bus_in.wdata;
            `TES_ADDR_IRQ_ST: state_next.irq_st = state_reg.irq_st & ~bus_in.wdata[1:0];
            `TES_ADDR_IRQ_MSK: state_next.irq_msk = bus_in.wdata[1:0];
            default: begin
            end
         endcase
      end

      // Reads, with their clearing side effects applied before any new sample.
      if (bus_in.rd) begin
         state_next.rdata = read_mux(state_reg, bus_in.addr);
         if (bus_in.addr == `TES_ADDR_INSIDE) begin
            state_next.in_flag = 3'h0;
            if (ile) begin
               state_next.ia = 1'b0;
            end
         end
         if (bus_in.addr == `TES_ADDR_EXCEED && ole) begin
            state_next.ot_flag = 3'h0;
            state_next.oa = 1'b0;
         end
      end

      // Per sample evaluation; a set in the same cycle as a read wins.
      if (odr_tick_in) begin
         for (int i = 0; i < 3; i++) begin
            inw[i] = inside_win(axes_in[i], state_reg.uth, state_reg.lth);
            above[i] = sext(axes_in[i]) >= sext(state_reg.uth);
         end
         outw = ~inw & out_en;
         o_cond = |outw;
         oc = deb_step(o_cond, state_reg.o_cnt);
         o_reach = o_cond && (oc >= state_reg.odb);
         state_next.o_cnt = oc;
         rise = outw & ~state_reg.ot_flag;
         if (ole) begin
            state_next.ot_flag = state_next.ot_flag | outw;
            if (o_reach && state_reg.o_arm) begin
               state_next.oa = 1'b1;
               state_next.o_arm = 1'b0;
            end
            if (!o_cond) begin
               state_next.o_arm = 1'b1;
            end
         end else begin
            state_next.ot_flag = outw;
            state_next.oa = o_reach;
            state_next.o_arm = 1'b1;
         end
         for (int i = 0; i < 3; i++) begin
            if (rise[i]) begin
               state_next.ot_pol[i] = above[i];
            end else if (!ole && outw[i] && o_reach) begin
               state_next.ot_pol[i] = above[i];
            end
         end

         // With no axis enabled both the all and the any terms stay false.
         if (state_reg.cfg2[`TES_C2_LOGIC_ANY]) begin
            i_cond = |(inw & in_en);
         end else begin
            i_cond = (in_en != 3'h0) && ((inw & in_en) == in_en);
         end
         ic = deb_step(i_cond, state_reg.i_cnt);
         i_reach = i_cond && (ic >= state_reg.idb);
         state_next.i_cnt = ic;
         if (ile) begin
            if (i_reach && state_reg.i_arm) begin
               state_next.ia = 1'b1;
               state_next.i_arm = 1'b0;
               state_next.in_flag = inw & in_en;
            end
            if (!i_cond) begin
               state_next.i_arm = 1'b1;
            end
         end else begin
            state_next.ia = i_reach;
            state_next.i_arm = 1'b1;
            if (i_reach) begin
               state_next.in_flag = inw & in_en;
            end else if (state_reg.idb == 8'h00) begin
               state_next.in_flag = inw & in_en;
            end
         end
         state_next.wake = state_reg.cfg4[`TES_C4_WAKE_HOLD] && state_reg.ia;
      end else begin
         i_cond = 1'b0;
         o_cond = 1'b0;
      end

      // Sticky events on the rise of each active flag.
      ev[`TES_IRQ_INSIDE] = state_next.ia & ~state_reg.ia;
      ev[`TES_IRQ_OUTSIDE] = state_next.oa & ~state_reg.oa;
      state_next.irq_st = state_next.irq_st | ev;
      state_next.irq = |(state_next.irq_st & state_next.irq_msk);

      // Pins carry the active levels themselves so the host sees them without a read.
      // Routing follows a config write at once, so a pin never moves in a quiet cycle.
      state_next.pin1 = pin_level(state_next.ia, state_next.oa, state_next.cfg4, 1'b0);
      state_next.pin2 = pin_level(state_next.ia, state_next.oa, state_next.cfg4, 1'b1);
   end

   ////////////////////////////////////////////////////////////////////////////////

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         state_reg <= '0;
         state_reg.cfg1 <= `TES_RST_CFG;
         state_reg.cfg2 <= `TES_RST_CFG;
         state_reg.cfg4 <= `TES_RST_CFG;
         state_reg.uth <= `TES_RST_UTH;
         state_reg.lth <= `TES_RST_LTH;
         state_reg.odb <= `TES_RST_DB;
         state_reg.idb <= `TES_RST_DB;
         state_reg.o_arm <= 1'b1;
         state_reg.i_arm <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   assign read_data_out = state_reg.rdata;
   assign irq_out = state_reg.irq;
   assign interrupt_pin_one_out = state_reg.pin1;
   assign interrupt_pin_two_out = state_reg.pin2;
   assign sleep_timer_restart_out = state_reg.wake;

endmodule

/* verif/tes_top_chk.sv */
`timescale 1ns/1ps
module tes_top_chk #(
   parameter int DATA_BITS = 12
) (
   // Clock and reset.
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   // Watched inputs.
   input wire logic odr_tick_in,
   input wire tes_pkg::tes_axes_type axes_in,
   input wire tes_pkg::tes_bus_type bus_in,
   // Watched outputs.
   input wire logic [7:0] read_data_out,
   input wire logic irq_out,
   input wire logic interrupt_pin_one_out,
   input wire logic interrupt_pin_two_out,
   input wire logic sleep_timer_restart_out
);
   import tes_pkg::*;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (sys_rst_in);
   logic any_acc;
   logic rd_ex;
   logic rd_in;
   logic pin_any;
   assign any_acc = odr_tick_in || bus_in.wr || bus_in.rd;
   assign rd_ex = bus_in.rd && (bus_in.addr == 8'h2d);
   assign rd_in = bus_in.rd && (bus_in.addr == 8'h2e);
   assign pin_any = interrupt_pin_one_out || interrupt_pin_two_out;
   ////////////////////////////////////////////////////////////////////////////////
   rdata_idle_a: assert property (!$past(bus_in.rd) |-> read_data_out == 8'h00)
      else $error("read data without a read");
   exceed_unused_a: assert property ($past(rd_ex) |-> !read_data_out[6])
      else $error("unused exceed bit set");
   inside_unused_a: assert property ($past(rd_in) |-> (read_data_out & 8'h55) == 8'h00)
      else $error("unused inside bit set");
   pin_one_hold_a: assert property (!$past(any_acc) |-> $stable(interrupt_pin_one_out))
      else $error("pin one moved without a sample");
   pin_two_hold_a: assert property (!$past(any_acc) |-> $stable(interrupt_pin_two_out))
      else $error("pin two moved without a sample");
   irq_hold_a: assert property (!$past(odr_tick_in) && !$past(bus_in.wr) |-> $stable(irq_out))
      else $error("irq moved without cause");
   wake_cause_a: assert property (sleep_timer_restart_out |-> $past(odr_tick_in) && $past(pin_any))
      else $error("timer restart without active flag");
   inside_route_a: assert property ($past(rd_in) && read_data_out[7] |-> $past(pin_any))
      else $error("active inside flag not on a pin");
   cover property (sleep_timer_restart_out);
   cover property ($rose(irq_out));
   cover property ($rose(interrupt_pin_two_out));
endmodule

bind tes_top tes_top_chk #(.DATA_BITS(DATA_BITS)) i_tes_top_chk (
   .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .odr_tick_in(odr_tick_in),
   .axes_in(axes_in), .bus_in(bus_in), .read_data_out(read_data_out), .irq_out(irq_out),
   .interrupt_pin_one_out(interrupt_pin_one_out),
   .interrupt_pin_two_out(interrupt_pin_two_out),
   .sleep_timer_restart_out(sleep_timer_restart_out)
);

/* verif/tes_host_model.sv */
`timescale 1ns/1ps
module tes_host_model (
   // Clock.
   input wire logic sys_clk_in,
   // Register port towards the block.
   output tes_pkg::tes_bus_type bus_out,
   input wire logic [7:0] read_data_in
);
   import tes_pkg::*;
   initial begin
      bus_out = '0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_in);
      bus_out <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk_in);
      bus_out.wr <= 1'b0;
   endtask
   // The status read clears the latched flags, so the host keeps the only copy.
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk_in);
      bus_out <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk_in);
      bus_out.rd <= 1'b0;
      #1;
      d = read_data_in;
   endtask
endmodule

/* verif/tb.sv */
`timescale 1ns/1ps
module tb;
   import tes_pkg::*;
   logic clk;
   logic rst;
   logic odr_tick;
   tes_axes_type axes;
   tes_bus_type bus;
   logic [7:0] rdata;
   logic irq;
   logic pin1;
   logic pin2;
   logic slp_out;
   logic slp;
   int fail_count = 0;
   int check_count = 0;
   localparam logic [15:0] v_up = 16'h0064;
   localparam logic [15:0] v_dn = 16'hff9c;
   localparam logic [15:0] v_far = 16'h03e8;
   localparam logic [15:0] v_0 = 16'h0000;

   tes_top i_tes_top (
      .sys_clk_in(clk), .sys_rst_in(rst), .odr_tick_in(odr_tick), .axes_in(axes),
      .bus_in(bus), .read_data_out(rdata), .irq_out(irq), .interrupt_pin_one_out(pin1),
      .interrupt_pin_two_out(pin2), .sleep_timer_restart_out(slp_out)
   );
   tes_host_model i_tes_host_model (.sys_clk_in(clk), .bus_out(bus), .read_data_in(rdata));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      if (fail_count == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      i_tes_host_model.rd_reg(a, d);
      chk(d, exp);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_tes_host_model.wr_reg(a, d);
   endtask
   task automatic tick(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
      @(posedge clk);
      axes <= {x, y, z};
      odr_tick <= 1'b1;
      @(posedge clk);
      odr_tick <= 1'b0;
      #1;
      slp = slp_out;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      stop_test();
   end
   initial begin
      rst = 1'b1;
      odr_tick = 1'b0;
      axes = '0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rdc(8'h2d, 8'h00);
      wr(8'h2e, 8'hff);
      rdc(8'h2e, 8'h00);
      rdc(8'h50, 8'h00);
      // Upper threshold 100, lower threshold -100 in twelve bits.
      wr(8'h31, 8'h64);
      wr(8'h32, 8'h00);
      wr(8'h33, 8'h9c);
      wr(8'h34, 8'h0f);
      wr(8'h2f, 8'h18);
      tick(v_up, v_up, v_dn);
      rdc(8'h2d, 8'h8e);
      tick(v_0, 16'h0063, 16'hff9d);
      rdc(8'h2d, 8'h04);
      wr(8'h35, 8'h03);
      tick(v_0, v_dn, v_0);
      rdc(8'h2d, 8'h08);
      tick(v_0, v_up, v_0);
      rdc(8'h2d, 8'h08);
      tick(v_0, v_up, v_0);
      rdc(8'h2d, 8'h8c);
      tick(v_0, v_0, v_0);
      rdc(8'h2d, 8'h04);
      tick(v_0, v_dn, v_0);
      rdc(8'h2d, 8'h08);
      // Inside window, all enabled axes, two samples of debounce.
      wr(8'h2f, 8'h06);
      wr(8'h36, 8'h02);
      wr(8'h38, 8'h03);
      tick(v_0, v_0, v_far);
      rdc(8'h2e, 8'h00);
      tick(v_0, v_0, v_far);
      chk({6'h00, pin2, pin1}, 8'h01);
      chk({7'h00, irq}, 8'h00);
      rdc(8'h2e, 8'ha8);
      rdc(8'h38, 8'h01);
      wr(8'h39, 8'h01);
      @(posedge clk);
      #1;
      chk({7'h00, irq}, 8'h01);
      wr(8'h38, 8'h01);
      @(posedge clk);
      #1;
      chk({7'h00, irq}, 8'h00);
      wr(8'h30, 8'h01);
      tick(v_0, v_far, v_0);
      rdc(8'h2e, 8'ha0);
      wr(8'h37, 8'h03);
      tick(v_0, v_far, v_0);
      chk({7'h00, slp}, 8'h01);
      chk({6'h00, pin2, pin1}, 8'h02);
      // All-axes mode with no axis enabled must not count as inside; stale flags stay.
      wr(8'h2f, 8'h00);
      wr(8'h30, 8'h00);
      tick(v_0, v_0, v_0);
      rdc(8'h2e, 8'h20);
      tick(v_0, v_0, v_0);
      chk({7'h00, slp}, 8'h00);
      wr(8'h2f, 8'h06);
      wr(8'h36, 8'h00);
      tick(v_0, v_far, v_0);
      rdc(8'h2e, 8'h20);
      // Latched inside events.
      wr(8'h2f, 8'h46);
      tick(v_0, v_0, v_0);
      tick(v_0, v_far, v_0);
      rdc(8'h2e, 8'ha8);
      rdc(8'h2e, 8'h00);
      tick(v_0, v_0, v_0);
      rdc(8'h2e, 8'ha8);
      tick(v_0, v_0, v_0);
      rdc(8'h2e, 8'h00);
      // Latched outside events, routed to the second pin.
      wr(8'h2f, 8'h90);
      wr(8'h35, 8'h01);
      wr(8'h37, 8'h04);
      tick(v_0, v_up, v_0);
      chk({6'h00, pin2, pin1}, 8'h02);
      tick(v_0, v_0, v_0);
      rdc(8'h2d, 8'h8c);
      rdc(8'h2d, 8'h04);
      stop_test();
   end
endmodule
